// ===== rtl/mcr_ctrl.sv
// Purpose: cpu control register with timed unlock sequences and irq gating
// Assumes: one access per cycle, instruction-done strobe from the core
// Notes:   register image is read back registered, one cycle after i_rd
//
// Summary of operation
// - decode at data 0x55 or io 0x35
// - extended io reachable by data space only
// - fixed bit positions, all zero at reset
// - debug port enabled by fuse unless disabled
// - debug disable changes after two matching writes
// - brownout off needs unlock write then set
// - brownout off active after three, clears
// - sleep while active turns brownout detector off
// - pullup kill disables every port pull-up
// - vector base select picks flash or boot
// - vector select changes only after unlock write
// - irq masked during vector move sequence
// - automatic masking leaves status i-bit alone
// - vector unlock self-clears after four cycles
// - boot lock bits block irqs by section
// - moved vector equals table plus boot base
`timescale 1ns/1ns
module mcr_ctrl
  import mcr_pkg::*;
(
  // clock, reset, enable
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  // cpu register access
  input  wire logic [15:0] i_addr,
  input  wire logic        i_io_space,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [7:0]  i_wdata,
  output logic [7:0]       o_rdata,
  output logic             o_ext_io_sel,
  // cpu core status
  input  wire logic        i_sleep_exec,
  input  wire logic        i_instr_done,
  input  wire logic        i_exec_boot,
  input  wire logic [5:0]  i_vec_num,
  // fuses and lock bits
  input  wire logic        i_debug_port_fuse,
  input  wire logic [1:0]  i_boot_size_fuses,
  input  wire logic        i_app_boot_lock_bit,
  input  wire logic        i_boot_boot_lock_bit,
  // port pins
  input  wire logic [7:0]  i_pin_direction_bit,
  input  wire logic [7:0]  i_pin_output_bit,
  // control outputs
  output logic             o_debug_port_en,
  output logic             o_bod_sleep_off,
  output logic             o_pullup_kill,
  output logic [7:0]       o_pullup_en,
  output logic             o_irq_block,
  output logic [16:0]      o_vector_addr
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // io addresses sit 0x20 below data space; only 64 of them exist
  function automatic logic [15:0] map_addr(input logic [15:0] a, input logic io);
    map_addr = io ? (16'(a[5:0]) + MCR_IO_SHIFT) : a;
  endfunction

  function automatic logic [16:0] boot_base(input logic [1:0] f);
    unique case (f)
      2'h0: boot_base = MCR_BOOT_BASE0;
      2'h1: boot_base = MCR_BOOT_BASE1;
      2'h2: boot_base = MCR_BOOT_BASE2;
      2'h3: boot_base = MCR_BOOT_BASE3;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic        dbg_r,  dbg_nxt;    // debug_port_disable
  logic        pend_r, pend_nxt;   // value awaiting its second write
  logic        brownout_sleep_off_r, brownout_sleep_off_nxt;   // brownout_sleep_off
  logic [1:0]  bcnt_r, bcnt_nxt;   // cycles since brownout_sleep_off set
  logic        puk_r,  puk_nxt;    // pullup_kill
  logic        vsel_r, vsel_nxt;   // vector_base_select
  logic        tail_r, tail_nxt;   // mask until next instruction ends
  logic [7:0]  rd_r,   rd_nxt;     // read data
  logic        wr;                 // write hit this cycle
  logic        dbg_arm, dbg_stop, dbg_open;
  logic        bu_arm,  bu_stop,  bu_open;
  logic        vc_arm,  vc_stop,  vc_open;
  logic        brownout_sleep_off_act;           // brownout off active
  logic        lock_blk;           // section lock gating
  logic [7:0]  image;              // register as read

  // i/o instructions can never reach extended io, data space can
  assign wr           = i_ce && i_wr && (map_addr(i_addr, i_io_space) == MCR_DATA_OFF);
  assign o_ext_io_sel = !i_io_space && (i_addr >= MCR_EXT_BASE)
                        && (i_addr <= MCR_EXT_END);

  ////////////////////////////////////////////////////////////////////////////
  // unlock windows, one per protected field
  assign dbg_arm  = wr && !(dbg_open && (i_wdata[MCR_B_DBG] == pend_r));
  assign dbg_stop = wr && !dbg_arm;
  assign bu_arm   = wr && i_wdata[MCR_B_BROWNOUT_SLEEP_OFF] && i_wdata[MCR_B_BODSU];
  assign bu_stop  = wr && bu_open && i_wdata[MCR_B_BROWNOUT_SLEEP_OFF] && !i_wdata[MCR_B_BODSU];
  assign vc_arm   = wr && i_wdata[MCR_B_VCHG];
  assign vc_stop  = wr && vc_open && !i_wdata[MCR_B_VCHG];

  mcr_window u_dbg_win (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce),
                        .i_arm(dbg_arm), .i_stop(dbg_stop), .o_open(dbg_open));
  mcr_window u_bu_win  (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce),
                        .i_arm(bu_arm), .i_stop(bu_stop), .o_open(bu_open));
  mcr_window u_vc_win  (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce),
                        .i_arm(vc_arm), .i_stop(vc_stop), .o_open(vc_open));

  ////////////////////////////////////////////////////////////////////////////
  // register image; unlock bits show their open windows
  always_comb
  begin
    image             = MCR_RESET;
    image[MCR_B_DBG]  = dbg_r;
    image[MCR_B_BROWNOUT_SLEEP_OFF] = brownout_sleep_off_r;
    image[MCR_B_BODSU]= bu_open;
    image[MCR_B_PUK]  = puk_r;
    image[MCR_B_VSEL] = vsel_r;
    image[MCR_B_VCHG] = vc_open;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state for all control fields
  always_comb
  begin
    dbg_nxt  = dbg_r;
    pend_nxt = pend_r;
    brownout_sleep_off_nxt = brownout_sleep_off_r;
    bcnt_nxt = bcnt_r;
    puk_nxt  = puk_r;
    vsel_nxt = vsel_r;
    tail_nxt = tail_r;
    rd_nxt   = 8'h00;
    // first write remembers the value, matching second write commits
    if (dbg_arm)
      pend_nxt = i_wdata[MCR_B_DBG];
    if (dbg_stop)
      dbg_nxt = pend_r;
    // brownout off runs a short fixed life then drops
    if (bu_stop)
    begin
      brownout_sleep_off_nxt = 1'b1;
      bcnt_nxt = 2'h0;
    end
    else if (brownout_sleep_off_r)
    begin
      bcnt_nxt = bcnt_r + 2'h1;
      if (bcnt_r == MCR_BROWNOUT_SLEEP_OFF_CYC)
        brownout_sleep_off_nxt = 1'b0;
    end
    // pullup kill is not protected
    if (wr)
      puk_nxt = i_wdata[MCR_B_PUK];
    // vector select only inside the unlock window
    if (vc_stop)
    begin
      vsel_nxt = i_wdata[MCR_B_VSEL];
      tail_nxt = 1'b1;
    end
    else if (tail_r && i_instr_done)
      tail_nxt = 1'b0;
    if (i_rd && (map_addr(i_addr, i_io_space) == MCR_DATA_OFF))
      rd_nxt = image;
  end

  // registers, frozen while clock enable is low
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      dbg_r  <= MCR_RESET[MCR_B_DBG];
      pend_r <= 1'b0;
      brownout_sleep_off_r <= MCR_RESET[MCR_B_BROWNOUT_SLEEP_OFF];
      bcnt_r <= 2'h0;
      puk_r  <= MCR_RESET[MCR_B_PUK];
      vsel_r <= MCR_RESET[MCR_B_VSEL];
      tail_r <= 1'b0;
      rd_r   <= 8'h00;
    end
    else if (i_ce)
    begin
      dbg_r  <= dbg_nxt;
      pend_r <= pend_nxt;
      brownout_sleep_off_r <= brownout_sleep_off_nxt;
      bcnt_r <= bcnt_nxt;
      puk_r  <= puk_nxt;
      vsel_r <= vsel_nxt;
      tail_r <= tail_nxt;
      rd_r   <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_rdata         = rd_r;
  assign o_debug_port_en = !dbg_r && i_debug_port_fuse;
  assign brownout_sleep_off_act        = brownout_sleep_off_r && (bcnt_r == MCR_BROWNOUT_SLEEP_OFF_CYC);
  assign o_bod_sleep_off = brownout_sleep_off_act && i_sleep_exec;
  assign o_pullup_kill   = puk_r;
  assign o_pullup_en     = ~i_pin_direction_bit & i_pin_output_bit & {8{!puk_r}};
  // locked section may not take irqs from the other one
  assign lock_blk        = (vsel_r && i_app_boot_lock_bit && !i_exec_boot)
                         || (!vsel_r && i_boot_boot_lock_bit && i_exec_boot);
  // separate gate: the status i-bit is never written from here
  assign o_irq_block     = vc_arm || vc_open || tail_r || lock_blk;
  assign o_vector_addr   = {10'h000, i_vec_num, 1'b0}
                         + (vsel_r ? boot_base(i_boot_size_fuses) : 17'h00000);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  io_decode_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && i_wr && i_io_space && i_addr[5:0] == MCR_IO_OFF) |=> puk_r == $past(i_wdata[MCR_B_PUK]))
    else $error("io write to control register not taken");
  dbg_change_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (dbg_r != $past(dbg_r)) |-> $past(wr && dbg_open))
    else $error("debug disable changed without second write");
  brownout_sleep_off_set_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $rose(brownout_sleep_off_r) |-> $past(wr && bu_open && !i_wdata[MCR_B_BODSU]))
    else $error("brownout off set without unlock");
  brownout_sleep_off_life_a: assert property (@(posedge i_mclk) disable iff (!i_rstn || !i_ce)
    $rose(brownout_sleep_off_r) |-> (brownout_sleep_off_r && !brownout_sleep_off_act)[*3] ##1 brownout_sleep_off_act ##1 !brownout_sleep_off_r)
    else $error("brownout off timing wrong");
  bod_off_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_bod_sleep_off |-> (brownout_sleep_off_r && $past(brownout_sleep_off_r, 3) && i_sleep_exec))
    else $error("brownout detector off outside active window");
  pullup_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    puk_r |-> (o_pullup_en == 8'h00))
    else $error("pull-up enabled while killed");
  vsel_chg_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (vsel_r != $past(vsel_r)) |-> $past(vc_open && wr && !i_wdata[MCR_B_VCHG]))
    else $error("vector select changed without unlock");
  mask_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rstn || !i_ce)
    vc_arm |-> o_irq_block[*3])
    else $error("irq not masked during vector unlock");
  vchg_clr_a: assert property (@(posedge i_mclk) disable iff (!i_rstn || !i_ce)
    (vc_arm ##1 !vc_arm[*4]) |=> !vc_open)
    else $error("vector unlock not cleared after four cycles");
  lock_blk_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (vsel_r && i_app_boot_lock_bit && !i_exec_boot) |-> o_irq_block)
    else $error("locked application section took irqs");
  vec_addr_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !vsel_r |-> (o_vector_addr == {10'h000, i_vec_num, 1'b0}))
    else $error("vector address wrong in flash start mode");
  unused_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_rdata[3:2] == 2'h0)
    else $error("unused bits read nonzero");

endmodule // mcr_ctrl

// ===== pkg/mcr_pkg.sv
// Purpose: constants shared by the control register bank and its unlock windows
// Assumes: byte-wide cpu register access, 16-bit data-space addresses
// Notes:   boot section bases are plain defaults, adjust per flash layout
package mcr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // address map
  localparam logic [15:0] MCR_DATA_OFF   = 16'h0055; // data-space offset
  localparam logic [5:0]  MCR_IO_OFF     = 6'h35;    // io-space offset
  localparam logic [15:0] MCR_IO_SHIFT   = 16'h0020; // io to data distance
  localparam logic [15:0] MCR_EXT_BASE   = 16'h0060; // extended io start
  localparam logic [15:0] MCR_EXT_END    = 16'h00FF; // extended io end

  ////////////////////////////////////////////////////////////////////////////
  // field positions and reset value
  localparam int          MCR_B_DBG      = 7;        // debug_port_disable
  localparam int          MCR_B_BROWNOUT_SLEEP_OFF     = 6;        // brownout_sleep_off
  localparam int          MCR_B_BODSU    = 5;        // brownout_sleep_unlock
  localparam int          MCR_B_PUK      = 4;        // pullup_kill
  localparam int          MCR_B_VSEL     = 1;        // vector_base_select
  localparam int          MCR_B_VCHG     = 0;        // vector_change_unlock
  localparam logic [7:0]  MCR_RESET      = 8'h00;    // register reset value

  ////////////////////////////////////////////////////////////////////////////
  // timing in cpu cycles
  localparam logic [2:0]  MCR_WIN_CYC    = 3'h4;     // unlock window length
  localparam logic [1:0]  MCR_BROWNOUT_SLEEP_OFF_CYC   = 2'h3;     // cycles to active/clear

  ////////////////////////////////////////////////////////////////////////////
  // boot section word base per boot_size_fuses code
  localparam logic [16:0] MCR_BOOT_BASE0 = 17'h1C000;
  localparam logic [16:0] MCR_BOOT_BASE1 = 17'h1E000;
  localparam logic [16:0] MCR_BOOT_BASE2 = 17'h1F000;
  localparam logic [16:0] MCR_BOOT_BASE3 = 17'h1F800;

endpackage

// ===== rtl/mcr_window.sv
// Purpose: timed unlock window, open for a fixed number of cycles after arming
// Assumes: arm and stop are single-cycle strobes in the cpu clock domain
// Notes:   arm wins over stop so a re-arm restarts the full window
`timescale 1ns/1ns
module mcr_window
  import mcr_pkg::*;
(
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  input  wire logic i_ce,
  // control
  input  wire logic i_arm,
  input  wire logic i_stop,
  // status
  output logic      o_open
);

  logic [2:0] cnt_r;   // cycles left in the window
  logic [2:0] cnt_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // next count: load, stop, or count down
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (i_arm)
      cnt_nxt = MCR_WIN_CYC;
    else if (i_stop)
      cnt_nxt = 3'h0;
    else if (cnt_r != 3'h0)
      cnt_nxt = cnt_r - 3'h1;
  end

  // register, frozen while clock enable is low
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
      cnt_r <= 3'h0;
    else if (i_ce)
      cnt_r <= cnt_nxt;
  end

  assign o_open = (cnt_r != 3'h0);

  // an arm loads the full window length on the next cycle
  win_bound_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && i_arm) |=> (cnt_r == MCR_WIN_CYC))
    else $error("unlock window did not load its length");

endmodule // mcr_window

// ===== verification/mcu_control_timed_register_tb_top.sv
// Purpose: self-checking bench for the cpu control register bank
// Assumes: one put call per clock cycle, inputs change 1 ns after the rising edge
// Notes:   debug disable is tested last, since two equal bit-7 writes within four cycles commit it
`timescale 1ns/1ns
module mcu_control_timed_register_tb_top
  import mcr_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////////
  // stimulus signals, one per design input
  logic        i_mclk = 1'b0, i_rstn = 1'b0, i_ce = 1'b1;     // clock, reset, enable
  logic [15:0] i_addr = 16'h0000;                              // access address
  logic        i_io_space = 1'b0, i_wr = 1'b0, i_rd = 1'b0;    // access kind
  logic [7:0]  i_wdata = 8'h00;                                // write data
  logic        i_sleep_exec = 1'b0, i_instr_done = 1'b0, i_exec_boot = 1'b0;
  logic [5:0]  i_vec_num = 6'h02;                              // vector to translate
  logic        i_debug_port_fuse = 1'b1;                       // fuse programmed
  logic [1:0]  i_boot_size_fuses = 2'h3;                       // boot size code
  logic        i_app_boot_lock_bit = 1'b0, i_boot_boot_lock_bit = 1'b0;
  logic [7:0]  i_pin_direction_bit = 8'h0F, i_pin_output_bit = 8'hFF;
  logic [7:0]  o_rdata, o_pullup_en;                           // observed outputs
  logic        o_ext_io_sel, o_debug_port_en, o_bod_sleep_off, o_pullup_kill, o_irq_block;
  logic [16:0] o_vector_addr;
  int          mismatches = 0, n_compared = 0;                 // score counters
  logic [16:0] bases [4] = '{MCR_BOOT_BASE0, MCR_BOOT_BASE1, MCR_BOOT_BASE2, MCR_BOOT_BASE3};

  mcr_ctrl u_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce), .i_addr(i_addr),
    .i_io_space(i_io_space), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .o_ext_io_sel(o_ext_io_sel), .i_sleep_exec(i_sleep_exec), .i_instr_done(i_instr_done),
    .i_exec_boot(i_exec_boot), .i_vec_num(i_vec_num), .i_debug_port_fuse(i_debug_port_fuse),
    .i_boot_size_fuses(i_boot_size_fuses), .i_app_boot_lock_bit(i_app_boot_lock_bit),
    .i_boot_boot_lock_bit(i_boot_boot_lock_bit), .i_pin_direction_bit(i_pin_direction_bit),
    .i_pin_output_bit(i_pin_output_bit), .o_debug_port_en(o_debug_port_en),
    .o_bod_sleep_off(o_bod_sleep_off), .o_pullup_kill(o_pullup_kill),
    .o_pullup_en(o_pullup_en), .o_irq_block(o_irq_block), .o_vector_addr(o_vector_addr));

  // 50 MHz clock
  always #10 i_mclk = ~i_mclk;

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // one access cycle; strobes stay up for back-to-back use
  task automatic put(input logic wr, input logic rd, input logic [15:0] a, input logic io,
                     input logic [7:0] d);
    i_wr = wr; i_rd = rd; i_addr = a; i_io_space = io; i_wdata = d;
    @(posedge i_mclk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] d);
    put(1'b1, 1'b0, MCR_DATA_OFF, 1'b0, d);
  endtask

  task automatic idle();
    put(1'b0, 1'b0, 16'h0000, 1'b0, 8'h00);
  endtask

  // read leaves o_rdata valid on return
  task automatic rd_reg(input logic [7:0] mask, input logic [7:0] exp);
    put(1'b0, 1'b1, MCR_DATA_OFF, 1'b0, 8'h00);
    chk(o_rdata & mask, exp);
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    // registers only take their reset values at a clock edge in reset
    repeat (5) @(posedge i_mclk);
    #1;
    chk(o_rdata, 8'h00);
    chk(o_debug_port_en, 1'b1);
    i_rstn = 1'b1;
    rd_reg(8'hFF, MCR_RESET);
  endtask

  // io alias, unused bits, unmapped places, extended io decode, pull-up kill
  task automatic t_map();
    put(1'b1, 1'b0, 16'h0035, 1'b1, 8'h1C);
    rd_reg(8'hFF, 8'h10);
    chk(o_pullup_en, 8'h00);
    chk(o_pullup_kill, 1'b1);
    put(1'b1, 1'b0, 16'h0056, 1'b0, 8'h00);
    put(1'b1, 1'b0, 16'h0035, 1'b0, 8'h00);
    rd_reg(8'hFF, 8'h10);
    wr_reg(8'h00);
    rd_reg(8'hFF, 8'h00);
    chk(o_pullup_en, ~i_pin_direction_bit & i_pin_output_bit);
    put(1'b0, 1'b0, 16'h0060, 1'b0, 8'h00);
    chk(o_ext_io_sel, 1'b1);
    put(1'b0, 1'b0, 16'h0060, 1'b1, 8'h00);
    chk(o_ext_io_sel, 1'b0);
    put(1'b0, 1'b0, 16'h005F, 1'b0, 8'h00);
    chk(o_ext_io_sel, 1'b0);
    // a write while the clock enable is low must leave no trace
    i_ce = 1'b0;
    wr_reg(8'h10);
    i_ce = 1'b1;
    chk(o_pullup_kill, 1'b0);
  endtask

  // lone set refused, then unlock and set with sleep held high
  task automatic t_brownout();
    i_sleep_exec = 1'b1;
    wr_reg(8'h40);
    rd_reg(8'h40, 8'h00);
    wr_reg(8'h60);
    wr_reg(8'h40);
    for (int k = 2; k <= 7; k++)
    begin
      chk(o_bod_sleep_off, k == 5);
      if (k == 3)
        chk(o_rdata & 8'h40, 8'h40);
      put(1'b0, k == 2, MCR_DATA_OFF, 1'b0, 8'h00);
    end
    // active window again, but no sleep: detector must stay on
    i_sleep_exec = 1'b0;
    wr_reg(8'h60);
    wr_reg(8'h40);
    repeat (3) idle();
    chk(o_bod_sleep_off, 1'b0);
  endtask

  // move then a refused change, then an unlock that times out
  task automatic t_vector();
    wr_reg(8'h01);
    chk(o_irq_block, 1'b1);
    idle();
    wr_reg(8'h02);
    chk(o_irq_block, 1'b1);
    chk(o_vector_addr, MCR_BOOT_BASE3 + 17'h00004);
    i_instr_done = 1'b1;
    idle();
    i_instr_done = 1'b0;
    chk(o_irq_block, 1'b0);
    rd_reg(8'h03, 8'h02);
    wr_reg(8'h00);
    rd_reg(8'h02, 8'h02);
    wr_reg(8'h03);
    for (int k = 1; k <= 5; k++)
    begin
      chk(o_irq_block, k < 5);
      if (k == 2)
        chk(o_rdata & 8'h01, 8'h01);
      put(1'b0, k == 1, MCR_DATA_OFF, 1'b0, 8'h00);
    end
    rd_reg(8'h03, 8'h02);
    for (int k = 0; k < 4; k++)
    begin
      i_boot_size_fuses = k[1:0];
      idle();
      chk(o_vector_addr, bases[k] + 17'h00004);
    end
  endtask

  // section lock gating with vectors in boot, then in application
  task automatic t_locks();
    i_app_boot_lock_bit = 1'b1;
    idle();
    chk(o_irq_block, 1'b1);
    i_exec_boot = 1'b1;
    idle();
    chk(o_irq_block, 1'b0);
    i_app_boot_lock_bit = 1'b0;
    wr_reg(8'h01);
    wr_reg(8'h00);
    i_instr_done = 1'b1;
    idle();
    i_instr_done = 1'b0;
    idle();
    chk(o_vector_addr, 17'h00004);
    i_boot_boot_lock_bit = 1'b1;
    idle();
    chk(o_irq_block, 1'b1);
    i_exec_boot = 1'b0;
    idle();
    chk(o_irq_block, 1'b0);
  endtask

  // lone write refused, then a matching pair inside the window commits
  task automatic t_debug();
    // no debug session runs here, so the disable bit may be changed
    wr_reg(8'h80);
    repeat (6) idle();
    rd_reg(8'h80, 8'h00);
    chk(o_debug_port_en, 1'b1);
    wr_reg(8'h80);
    idle();
    wr_reg(8'h80);
    idle();
    rd_reg(8'h80, 8'h80);
    chk(o_debug_port_en, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial
  begin
    t_reset();
    t_map();
    t_brownout();
    t_vector();
    t_locks();
    t_debug();
    wrap_up();
  end

  // the whole run is well under 200 cycles, so 2000 means a hang
  initial
  begin
    repeat (2000) @(posedge i_mclk);
    mismatches++;
    wrap_up();
  end

endmodule // mcu_control_timed_register_tb_top
